// [lcvr_pkg.sv]
// Package with offsets, field positions, reset values and codes for the global register slice.
package lcvr_pkg;
    localparam logic [7:0] LCVR_OFF_E7 = 8'he7;
    localparam logic [7:0] LCVR_OFF_COUNT = 8'he8;
    localparam logic [7:0] LCVR_OFF_REFERENCE_FREQ_CODE = 8'he9;
    localparam logic [7:0] LCVR_OFF_IRQ = 8'hea;
    localparam logic [7:0] LCVR_OFF_CHSEL = 8'he5;
    localparam logic [7:0] LCVR_OFF_CTRL = 8'he6;
    localparam int LCVR_CTRL_ALLUPD_BIT = 3;
    localparam int LCVR_CTRL_BYTE_BIT = 2;
    localparam int LCVR_CTRL_CHUPD_BIT = 1;
    localparam int LCVR_CLK_FILL_BIT = 4;
    localparam int LCVR_IRQ_LO_CH = 4;
    localparam logic [7:0] LCVR_RESET_BYTE = 8'h00;
    localparam logic [3:0] LCVR_CHSEL_NONE = 4'h0;
    localparam logic [3:0] LCVR_CHSEL_NONE_HI = 4'hf;
    localparam logic [15:0] LCVR_COUNT_RESET = 16'h0000;
    typedef enum logic [2:0] {
        LCVR_REF_2048,
        LCVR_REF_1544,
        LCVR_REF_4096,
        LCVR_REF_3088,
        LCVR_REF_8192,
        LCVR_REF_6176,
        LCVR_REF_16384
    } lcvr_ref_e;
endpackage : lcvr_pkg

// [lcvr_global_regs.sv]
// Global register slice: counter readout, clock select, channel interrupt status.
`timescale 1ns/1ns
module lcvr_global_regs
    import lcvr_pkg::*;
#(
    parameter int NUM_CH = 14,
    parameter int IRQ_CH = 4
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic [3:0] count_channel_choice_i,
    input wire logic [7:0] count_ctrl_i,
    input wire logic [NUM_CH*16-1:0] line_code_violation_i,
    input wire logic [IRQ_CH-1:0] channel_irq_event_i,
    input wire logic transmit_clock_present_i,
    input wire logic tx_data_i,
    output logic line_driver_data_o,
    output logic [3:0] reference_freq_code_o,
    output lcvr_ref_e ref_freq_o,
    output logic pll_retune_o
);
    // Reset is released through two flops so that every register leaves reset on one edge.
    // Only the second flop is read elsewhere; the first may still be settling.
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    function automatic logic chan_valid(input logic [3:0] code);
        chan_valid = (code != LCVR_CHSEL_NONE) && (code != LCVR_CHSEL_NONE_HI)
            && ({28'h0, code} <= NUM_CH);
    endfunction : chan_valid

    logic [7:0] clk_sel_reg, clk_sel_next;
    logic [IRQ_CH-1:0] irq_reg, irq_next;
    logic [15:0] hold_reg [NUM_CH];
    logic [15:0] hold_next [NUM_CH];
    logic [7:0] rdata_reg, rdata_next;
    logic retune_reg, retune_next;
    logic prev_ch_upd_reg, prev_all_upd_reg;
    logic ch_upd_rise, all_upd_rise;
    logic [3:0] ch_idx;

    assign ch_upd_rise = count_ctrl_i[LCVR_CTRL_CHUPD_BIT] && !prev_ch_upd_reg;
    assign all_upd_rise = count_ctrl_i[LCVR_CTRL_ALLUPD_BIT] && !prev_all_upd_reg;
    assign ch_idx = count_channel_choice_i - 4'h1;

    always_comb begin
        clk_sel_next = clk_sel_reg;
        retune_next = 1'b0;
        irq_next = irq_reg | channel_irq_event_i;
        rdata_next = rdata_reg;
        for (int i = 0; i < NUM_CH; i++) begin
            hold_next[i] = hold_reg[i];
            if (all_upd_rise || (ch_upd_rise && chan_valid(count_channel_choice_i)
                && ch_idx == i[3:0])) begin
                hold_next[i] = line_code_violation_i[i*16 +: 16];
            end
        end
        if (wr_i && addr_i == LCVR_OFF_REFERENCE_FREQ_CODE) begin
            // Reserved bits stay zero; the host keeps each write to one sub-field.
            clk_sel_next = {3'h0, wdata_i[4:0]};
            retune_next = (wdata_i[3:0] != clk_sel_reg[3:0]);
        end
        if (rd_i) begin
            case (addr_i)
                LCVR_OFF_E7: rdata_next = LCVR_RESET_BYTE;
                LCVR_OFF_COUNT: begin
                    if (!chan_valid(count_channel_choice_i)) begin
                        rdata_next = LCVR_RESET_BYTE;
                    end else if (count_ctrl_i[LCVR_CTRL_BYTE_BIT]) begin
                        rdata_next = hold_reg[ch_idx][15:8];
                    end else begin
                        rdata_next = hold_reg[ch_idx][7:0];
                    end
                end
                LCVR_OFF_REFERENCE_FREQ_CODE: rdata_next = clk_sel_reg;
                LCVR_OFF_IRQ: begin
                    rdata_next = {irq_reg, {LCVR_IRQ_LO_CH{1'b0}}};
                    // A new event in the read cycle survives the clear.
                    irq_next = channel_irq_event_i;
                end
                default: rdata_next = LCVR_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            clk_sel_reg <= LCVR_RESET_BYTE;
            irq_reg <= '0;
            rdata_reg <= LCVR_RESET_BYTE;
            retune_reg <= 1'b0;
            prev_ch_upd_reg <= 1'b0;
            prev_all_upd_reg <= 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                hold_reg[i] <= LCVR_COUNT_RESET;
            end
        end else begin
            clk_sel_reg <= clk_sel_next;
            irq_reg <= irq_next;
            rdata_reg <= rdata_next;
            retune_reg <= retune_next;
            prev_ch_upd_reg <= count_ctrl_i[LCVR_CTRL_CHUPD_BIT];
            prev_all_upd_reg <= count_ctrl_i[LCVR_CTRL_ALLUPD_BIT];
            for (int i = 0; i < NUM_CH; i++) begin
                hold_reg[i] <= hold_next[i];
            end
        end
    end

    always_comb begin
        case (clk_sel_reg[3:0])
            4'h0, 4'he: ref_freq_o = LCVR_REF_2048;
            4'h1, 4'hf: ref_freq_o = LCVR_REF_1544;
            4'h8: ref_freq_o = LCVR_REF_4096;
            4'h9: ref_freq_o = LCVR_REF_3088;
            4'ha: ref_freq_o = LCVR_REF_8192;
            4'hb: ref_freq_o = LCVR_REF_6176;
            4'hc: ref_freq_o = LCVR_REF_16384;
            default: ref_freq_o = LCVR_REF_2048;
        endcase
    end

    assign rdata_o = rdata_reg;
    assign reference_freq_code_o = clk_sel_reg[3:0];
    assign pll_retune_o = retune_reg;
    // Fill is chosen only while the transmit clock is absent.
    assign line_driver_data_o = transmit_clock_present_i ? tx_data_i
        : clk_sel_reg[LCVR_CLK_FILL_BIT];

    chk_fill_pattern: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        !transmit_clock_present_i |-> line_driver_data_o == clk_sel_reg[LCVR_CLK_FILL_BIT])
        else $error("fill pattern wrong");
    chk_reserved_read: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        rd_i && addr_i == LCVR_OFF_E7 |=> rdata_o == 8'h00)
        else $error("reserved register not zero");
    chk_none_channel: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        rd_i && addr_i == LCVR_OFF_COUNT && !chan_valid(count_channel_choice_i)
        |=> rdata_o == 8'h00)
        else $error("unselected channel readout not zero");
    chk_irq_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        rd_i && addr_i == LCVR_OFF_IRQ |=> irq_reg == $past(channel_irq_event_i))
        else $error("status not cleared on read");
    chk_irq_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        channel_irq_event_i[0] |=> irq_reg[0])
        else $error("status event lost");
    chk_irq_lownib: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        rd_i && addr_i == LCVR_OFF_IRQ |=> rdata_o[3:0] == 4'h0 && rdata_o[7:4] == $past(irq_reg))
        else $error("status read wrong");
    chk_retune_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        wr_i && addr_i == LCVR_OFF_REFERENCE_FREQ_CODE && wdata_i[3:0] != reference_freq_code_o
        |=> pll_retune_o ##1 (!pll_retune_o || $past(wr_i && addr_i == LCVR_OFF_REFERENCE_FREQ_CODE)))
        else $error("retune pulse missing");
    chk_clk_write: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        wr_i && addr_i == LCVR_OFF_REFERENCE_FREQ_CODE |=> clk_sel_reg == {3'h0, $past(wdata_i[4:0])})
        else $error("clock select not stored");
    chk_all_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        all_upd_rise |=> hold_reg[0] == $past(line_code_violation_i[15:0]))
        else $error("counter not latched");

    // Readout checks look at the holding copy, so a moving live counter never leaks out.
    chk_chan_latch: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        ch_upd_rise && chan_valid(count_channel_choice_i)
        |=> hold_reg[$past(ch_idx)] == $past(line_code_violation_i[ch_idx*16 +: 16]))
        else $error("selected counter not latched");
    chk_count_low: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        rd_i && addr_i == LCVR_OFF_COUNT && chan_valid(count_channel_choice_i)
        && !count_ctrl_i[LCVR_CTRL_BYTE_BIT] |=> rdata_o == $past(hold_reg[ch_idx][7:0]))
        else $error("counter low byte wrong");
    chk_count_high: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        rd_i && addr_i == LCVR_OFF_COUNT && chan_valid(count_channel_choice_i)
        && count_ctrl_i[LCVR_CTRL_BYTE_BIT] |=> rdata_o == $past(hold_reg[ch_idx][15:8]))
        else $error("counter high byte wrong");
    chk_retune_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        !(wr_i && addr_i == LCVR_OFF_REFERENCE_FREQ_CODE) |=> !pll_retune_o)
        else $error("retune pulse without write");
    chk_rdata_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        !rd_i |=> $stable(rdata_o))
        else $error("read data moved without a read");
    chk_freq_top: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        reference_freq_code_o == 4'hc |-> ref_freq_o == LCVR_REF_16384)
        else $error("top reference frequency wrong");
    chk_clk_reserved: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        clk_sel_reg[7:5] == 3'h0)
        else $error("clock select reserved bits set");

    cov_count_read: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        rd_i && addr_i == LCVR_OFF_COUNT && chan_valid(count_channel_choice_i));
    cov_irq_read: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        rd_i && addr_i == LCVR_OFF_IRQ && irq_reg != '0);
    cov_retune: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_reg) pll_retune_o);
    cov_set_wins: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        rd_i && addr_i == LCVR_OFF_IRQ && channel_irq_event_i != '0);
    cov_fill_ones: cover property (@(posedge ref_clk_i) disable iff (!rst_sync_reg)
        !transmit_clock_present_i && line_driver_data_o);
endmodule : lcvr_global_regs

// [lcvr_host_model.sv]
// Host processor model that drives the register strobes of the global slice.
`timescale 1ns/1ns
module lcvr_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [7:0] wdata_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // Callers change only D4 or only D[3:0] of the clock register per write.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        // Idle lines show the inverse, so a stale value is never taken.
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask : rd_reg
endmodule : lcvr_host_model

// [lcvr_global_regs_tb.sv]
// Self-checking bench for the global register slice.
`timescale 1ns/1ns
module lcvr_global_regs_tb;
    import lcvr_pkg::*;
    logic clk, rst_n, wr, rd, clk_ok, txd, line, retune;
    logic [7:0] addr, wdata, rdata, ctrl, v;
    logic [3:0] chsel, irq, code;
    logic [223:0] live;
    lcvr_ref_e freq;
    int err_total, checks;
    logic [3:0] codes [10] = '{4'h1, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf, 4'h5, 4'h0};
    lcvr_ref_e exp_f [10] = '{LCVR_REF_1544, LCVR_REF_4096, LCVR_REF_3088, LCVR_REF_8192,
        LCVR_REF_6176, LCVR_REF_16384, LCVR_REF_2048, LCVR_REF_1544,
        LCVR_REF_2048, LCVR_REF_2048};
    logic [7:0] probe_addr [4] = '{LCVR_OFF_E7, LCVR_OFF_COUNT, LCVR_OFF_IRQ, 8'he0};
    lcvr_host_model lcvr_host_model_i (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
        .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
    lcvr_global_regs lcvr_global_regs_i (.ref_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
        .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .count_channel_choice_i(chsel),
        .count_ctrl_i(ctrl), .line_code_violation_i(live), .channel_irq_event_i(irq),
        .transmit_clock_present_i(clk_ok), .tx_data_i(txd), .line_driver_data_o(line),
        .reference_freq_code_o(code), .ref_freq_o(freq), .pll_retune_o(retune));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    // Updates latch on a rising control bit, so the bit is raised and dropped again.
    task automatic latch(input logic [7:0] m);
        @(posedge clk);
        ctrl <= ctrl | m;
        repeat (2) @(posedge clk);
        ctrl <= ctrl & ~m;
        @(posedge clk);
    endtask : latch
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        err_total++;
        end_of_test();
    end
    initial begin
        {rst_n, clk_ok, txd, chsel, ctrl, irq} = '0;
        for (int i = 0; i < 14; i++) live[i*16 +: 16] = 16'(i * 16'h0111 + 16'h1001);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        cmp({4'h0, code}, 8'h00);
        foreach (probe_addr[i]) begin
            lcvr_host_model_i.rd_reg(probe_addr[i], v);
            cmp(v, 8'h00);
            lcvr_host_model_i.wr_reg(probe_addr[i], 8'hff);
            lcvr_host_model_i.rd_reg(probe_addr[i], v);
            cmp(v, 8'h00);
        end
        $display("test reset and reserved done");
        for (int c = 0; c < 14; c++) begin
            @(posedge clk);
            chsel <= 4'(c + 1);
            ctrl <= 8'h00;
            latch(8'h02);
            lcvr_host_model_i.rd_reg(LCVR_OFF_COUNT, v);
            cmp(v, live[c*16 +: 8]);
            ctrl <= 8'h04;
            lcvr_host_model_i.rd_reg(LCVR_OFF_COUNT, v);
            cmp(v, live[c*16+8 +: 8]);
        end
        live <= ~live;
        chsel <= 4'h3;
        ctrl <= 8'h00;
        lcvr_host_model_i.rd_reg(LCVR_OFF_COUNT, v);
        cmp(v, ~live[39:32]);
        latch(8'h08);
        lcvr_host_model_i.rd_reg(LCVR_OFF_COUNT, v);
        cmp(v, live[39:32]);
        chsel <= 4'hf;
        lcvr_host_model_i.rd_reg(LCVR_OFF_COUNT, v);
        cmp(v, 8'h00);
        $display("test counter readout done");
        foreach (codes[i]) begin
            lcvr_host_model_i.wr_reg(LCVR_OFF_REFERENCE_FREQ_CODE, {4'h0, codes[i]});
            cmp({7'h00, retune}, 8'h01);
            cmp(8'(freq), 8'(exp_f[i]));
            cmp({4'h0, code}, {4'h0, codes[i]});
            lcvr_host_model_i.rd_reg(LCVR_OFF_REFERENCE_FREQ_CODE, v);
            cmp(v, {4'h0, codes[i]});
        end
        lcvr_host_model_i.wr_reg(LCVR_OFF_REFERENCE_FREQ_CODE, 8'h10);
        cmp({7'h00, retune}, 8'h00);
        cmp({7'h00, line}, 8'h01);
        lcvr_host_model_i.wr_reg(LCVR_OFF_REFERENCE_FREQ_CODE, 8'h00);
        cmp({7'h00, line}, 8'h00);
        lcvr_host_model_i.wr_reg(LCVR_OFF_REFERENCE_FREQ_CODE, 8'h0c);
        cmp({7'h00, retune}, 8'h01);
        lcvr_host_model_i.wr_reg(LCVR_OFF_REFERENCE_FREQ_CODE, 8'h1c);
        cmp({7'h00, retune}, 8'h00);
        cmp({7'h00, line}, 8'h01);
        cmp(8'(freq), 8'(LCVR_REF_16384));
        clk_ok <= 1'b1;
        @(posedge clk);
        #1;
        cmp({7'h00, line}, 8'h00);
        txd <= 1'b1;
        @(posedge clk);
        #1;
        cmp({7'h00, line}, 8'h01);
        $display("test clock select done");
        for (int p = 5; p <= 10; p += 5) begin
            @(posedge clk);
            irq <= 4'(p);
            @(posedge clk);
            irq <= 4'h0;
            lcvr_host_model_i.rd_reg(LCVR_OFF_IRQ, v);
            cmp(v, 8'(p << 4));
            lcvr_host_model_i.rd_reg(LCVR_OFF_IRQ, v);
            cmp(v, 8'h00);
        end
        @(posedge clk);
        irq <= 4'h3;
        lcvr_host_model_i.rd_reg(LCVR_OFF_IRQ, v);
        irq <= 4'h0;
        cmp(v, 8'h30);
        lcvr_host_model_i.rd_reg(LCVR_OFF_IRQ, v);
        cmp(v, 8'h30);
        lcvr_host_model_i.rd_reg(LCVR_OFF_IRQ, v);
        cmp(v, 8'h00);
        $display("test interrupt status done");
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        cmp({4'h0, code}, 8'h00);
        lcvr_host_model_i.rd_reg(LCVR_OFF_REFERENCE_FREQ_CODE, v);
        cmp(v, 8'h00);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule : lcvr_global_regs_tb
